// File: logic/ebc_bus_ctrl.sv
// ----------------------------------------------------------------
// external bus cycle controller
// ----------------------------------------------------------------
module ebc_bus_ctrl (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  // internal request side
  input wire logic req_in, // one-cycle request pulse when idle
  input wire logic write_in,
  input wire logic [1:0] size_in,
  input wire logic [23:0] addr_in,
  input wire logic [2:0] fc_in,
  input wire logic [31:0] wdata_in,
  input wire logic [3:0] ack_option_in, // chip select acknowledge option
  input wire logic [1:0] monitor_timeout_field_in,
  output logic busy_out,
  output logic done_out,
  output logic bus_error_out,
  output logic [31:0] rdata_out,
  // external pins
  output logic [23:0] address_out,
  output logic [1:0] transfer_size_out,
  output logic [2:0] function_code_out,
  output logic rw_out, // high for read
  output logic address_strobe_n_out,
  output logic data_strobe_n_out,
  output logic [15:0] data_out,
  output logic data_oe_out,
  input wire logic [15:0] data_in,
  input wire logic [1:0] size_acknowledge_n_in,
  input wire logic bus_error_line_n_in,
  input wire logic halt_n_in
);
  // --------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------
  logic [1:0] ack_meta_reg, ack_sync_reg; // acknowledge sync
  logic bus_error_line_meta_reg, bus_error_line_sync_reg; // bus error sync
  logic halt_meta_reg, halt_sync_reg; // halt sync (never read; halt is ignored)
  logic [15:0] data_meta_reg, data_sync_reg; // read data sync

  // two flops before any logic reads an external pin
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      ack_meta_reg <= ebc_pkg::EBC_ACK_NONE;
      ack_sync_reg <= ebc_pkg::EBC_ACK_NONE;
      bus_error_line_meta_reg <= 1'b1;
      bus_error_line_sync_reg <= 1'b1;
      halt_meta_reg <= 1'b1;
      halt_sync_reg <= 1'b1;
      data_meta_reg <= 16'h0000;
      data_sync_reg <= 16'h0000;
    end else if (ce_in) begin
      ack_meta_reg <= size_acknowledge_n_in;
      ack_sync_reg <= ack_meta_reg;
      bus_error_line_meta_reg <= bus_error_line_n_in;
      bus_error_line_sync_reg <= bus_error_line_meta_reg;
      halt_meta_reg <= halt_n_in;
      halt_sync_reg <= halt_meta_reg;
      data_meta_reg <= data_in;
      data_sync_reg <= data_meta_reg;
    end
  end

  // --------------------------------------------------------------
  // request capture and sequencing
  // --------------------------------------------------------------
  ebc_pkg::ebc_state_t state_reg;
  logic fast_reg; // fast termination selected
  logic second_reg; // second word of a long operand
  logic port8_reg; // responding port is 8 bits
  logic [6:0] mon_count_reg; // bus monitor cycle counter
  logic [6:0] mon_limit; // selected monitor period
  logic [1:0] cnt_reg; // clocks since strobes asserted
  logic ack_seen; // any acknowledge line low
  logic err_seen; // bus error (halt alone does not count)
  logic pins_valid; // synchronised pins now belong to this cycle
  logic [15:0] lane_rdata; // steered read data
  logic [15:0] lane_wdata; // steered write data
  logic [15:0] word_wdata; // write word for this cycle

  // the synchronisers lag the pins by two clocks, so in the first wait clocks
  // they still show the previous cycle; a peripheral that holds acknowledge
  // until the strobes negate would otherwise end the next word at once
  assign pins_valid = (cnt_reg >= 2'(ebc_pkg::EBC_SYNC_CLOCKS));
  // either acknowledge line low ends the wait
  assign ack_seen = pins_valid && (ack_sync_reg != ebc_pkg::EBC_ACK_NONE);
  // error with halt is treated as plain error; halt alone is ignored
  assign err_seen = pins_valid && !bus_error_line_sync_reg;
  // long operand: high word first, low word next
  // word and byte operands always travel in the low half of the request word
  assign word_wdata = (transfer_size_out == ebc_pkg::EBC_SIZE_LONG && !second_reg)
      ? wdata_in[31:16] : wdata_in[15:0];

  // period from the timeout field; longest is 64 clocks
  // a shift keeps the four periods exact powers of two
  always_comb begin
    mon_limit = 7'(ebc_pkg::EBC_MONITOR_MAX_CLOCKS >> monitor_timeout_field_in);
  end

  ebc_lane_mux lane_mux (
    .size_in(transfer_size_out),
    .low_address_bit_in(address_out[0]),
    .port8_in(port8_reg),
    .wdata_in(word_wdata),
    .bus_in(data_sync_reg),
    .bus_out(lane_wdata),
    .rdata_out(lane_rdata)
  );

  // --------------------------------------------------------------
  // main bus sequencer
  // --------------------------------------------------------------
  // one state per phase of the cycle; a long operand loops back to the
  // address phase once for its low word
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_reg <= ebc_pkg::EBC_IDLE;
      fast_reg <= 1'b0;
      second_reg <= 1'b0;
      port8_reg <= 1'b0;
      cnt_reg <= 2'h0;
      mon_count_reg <= 7'h00;
      address_out <= 24'h000000;
      transfer_size_out <= 2'h0;
      function_code_out <= 3'h0;
      rw_out <= 1'b1;
      address_strobe_n_out <= 1'b1;
      data_strobe_n_out <= 1'b1;
      data_out <= 16'h0000;
      data_oe_out <= 1'b0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
      bus_error_out <= 1'b0;
      rdata_out <= 32'h00000000;
    end else if (ce_in) begin
      done_out <= 1'b0;
      case (state_reg)
        ebc_pkg::EBC_IDLE: begin
          bus_error_out <= 1'b0;
          // request is only looked at here, so a pulse while busy is dropped
          if (req_in) begin
            // present address and size first
            address_out <= addr_in;
            transfer_size_out <= size_in;
            rw_out <= !write_in;
            // function code tagged; cpu-space type sits in addr 19..16
            function_code_out <= fc_in;
            fast_reg <= (ack_option_in == ebc_pkg::EBC_ACK_OPT_FAST);
            second_reg <= 1'b0;
            port8_reg <= 1'b0;
            busy_out <= 1'b1;
            state_reg <= ebc_pkg::EBC_ADDR;
          end
        end
        ebc_pkg::EBC_ADDR: begin
          // strobes assert; fc only valid from here
          address_strobe_n_out <= 1'b0;
          // fast writes do not assert data strobe
          data_strobe_n_out <= fast_reg && !rw_out;
          data_oe_out <= !rw_out;
          data_out <= lane_wdata;
          cnt_reg <= 2'h0;
          mon_count_reg <= 7'h00;
          state_reg <= ebc_pkg::EBC_WAIT;
        end
        ebc_pkg::EBC_WAIT: begin
          mon_count_reg <= mon_count_reg + 7'h01;
          if (cnt_reg != 2'h3) begin
            cnt_reg <= cnt_reg + 2'h1;
          end
          if (fast_reg) begin
            // internal acknowledge two clocks after the strobes, no pin sampling
            // the second clock lets read data cross the data synchroniser
            if (cnt_reg == 2'(ebc_pkg::EBC_FAST_CLOCKS - 1)) begin
              port8_reg <= 1'b0;
              state_reg <= ebc_pkg::EBC_LATCH;
            end
          end else if (err_seen || mon_count_reg >= mon_limit) begin
            // monitor cannot be disabled
            bus_error_out <= 1'b1;
            state_reg <= ebc_pkg::EBC_END;
          end else if (ack_seen) begin
            // record port width from the acknowledge code
            port8_reg <= (ack_sync_reg == ebc_pkg::EBC_ACK_PORT8);
            state_reg <= ebc_pkg::EBC_LATCH;
          end
        end
        ebc_pkg::EBC_LATCH: begin
          // data taken one clock after the acknowledge
          if (rw_out) begin
            if (transfer_size_out == ebc_pkg::EBC_SIZE_LONG && !second_reg) begin
              rdata_out[31:16] <= lane_rdata;
            end else begin
              rdata_out[15:0] <= lane_rdata;
            end
          end
          state_reg <= ebc_pkg::EBC_END;
        end
        default: begin
          // negate strobes to close the cycle
          address_strobe_n_out <= 1'b1;
          data_strobe_n_out <= 1'b1;
          data_oe_out <= 1'b0;
          // a bus error aborts a long operand: its low word is never moved
          if (!bus_error_out && transfer_size_out == ebc_pkg::EBC_SIZE_LONG
              && !second_reg) begin
            // second word of a long operand at address + 2
            second_reg <= 1'b1;
            transfer_size_out <= ebc_pkg::EBC_SIZE_WORD;
            address_out <= address_out + 24'h000002;
            state_reg <= ebc_pkg::EBC_ADDR;
          end else begin
            busy_out <= 1'b0;
            done_out <= 1'b1;
            state_reg <= ebc_pkg::EBC_IDLE;
          end
        end
      endcase
    end
  end
endmodule

// File: logic/ebc_pkg.sv
package ebc_pkg;
  // Contract
  // - drive address and transfer size to start
  // - three clocks minimum, waits until acknowledge
  // - bus monitor errors after timeout, max 64
  // - error plus halt acts as error alone
  // - word reads fetch two bytes, byte one (through an 8-bit port the code runs one cycle and fetches only the high byte)
  // - word writes send two bytes, byte one (via an 8-bit port the code runs one cycle; only the upper-lane byte arrives)
  // - lanes chosen by size, address, port
  // - fast termination completes in two clocks
  // - acknowledge option 1110 selects fast termination
  // - fast writes keep data strobe negated
  // - function code valid only with address strobe
  // - cpu space type on address 19..16
  // - long through 16-bit port: high word first
  // - read data latched one clock after acknowledge

  // --------------------------------------------------------------
  // transfer size encodings
  // --------------------------------------------------------------
  localparam logic [1:0] EBC_SIZE_LONG = 2'h0;
  localparam logic [1:0] EBC_SIZE_BYTE = 2'h1;
  localparam logic [1:0] EBC_SIZE_WORD = 2'h2;
  localparam logic [1:0] EBC_SIZE_THREE = 2'h3;

  // size acknowledge (active low): port width codes
  localparam logic [1:0] EBC_ACK_PORT8 = 2'h2;
  localparam logic [1:0] EBC_ACK_PORT16 = 2'h1;
  localparam logic [1:0] EBC_ACK_NONE = 2'h3;

  // acknowledge option code for fast termination
  localparam logic [3:0] EBC_ACK_OPT_FAST = 4'hE;

  // function codes and cpu-space cycle types
  localparam logic [2:0] EBC_FC_CPU_SPACE = 3'h7;
  localparam logic [3:0] EBC_CPU_TYPE_BKPT = 4'h0;
  localparam logic [3:0] EBC_CPU_TYPE_LPSTOP = 4'h3;
  localparam logic [3:0] EBC_CPU_TYPE_IACK = 4'hF;
  localparam int EBC_CPU_TYPE_LSB = 16;

  // --------------------------------------------------------------
  // timing
  // --------------------------------------------------------------
  localparam int EBC_MIN_REGULAR_CLOCKS = 3;
  localparam int EBC_FAST_CLOCKS = 2;
  localparam int EBC_MONITOR_MAX_CLOCKS = 64;
  // clocks a pin needs to cross its two-flop synchroniser
  localparam int EBC_SYNC_CLOCKS = 2;
  // monitor timeout field: 0..3 selects 64, 32, 16, 8 clocks
  localparam logic [1:0] EBC_MONITOR_FIELD_RESET = 2'h0;

  // bus sequencer states
  typedef enum logic [2:0] {
    EBC_IDLE = 3'b000,
    EBC_ADDR = 3'b001,
    EBC_WAIT = 3'b010,
    EBC_LATCH = 3'b011,
    EBC_END = 3'b100
  } ebc_state_t;
endpackage

// File: logic/ebc_lane_mux.sv
// ----------------------------------------------------------------
// byte lane steering for one bus cycle
// ----------------------------------------------------------------
module ebc_lane_mux (
  input wire logic [1:0] size_in,
  input wire logic low_address_bit_in,
  input wire logic port8_in,
  input wire logic [15:0] wdata_in,
  input wire logic [15:0] bus_in,
  output logic [15:0] bus_out,
  output logic [15:0] rdata_out
);
  // lane choice depends on operand size, address and port width
  always_comb begin
    bus_out = wdata_in;
    rdata_out = bus_in;
    if (size_in == ebc_pkg::EBC_SIZE_BYTE) begin
      // single byte: duplicate onto both lanes on writes
      bus_out = {wdata_in[7:0], wdata_in[7:0]};
      if (port8_in || !low_address_bit_in) begin
        rdata_out = {8'h00, bus_in[15:8]};
      end else begin
        rdata_out = {8'h00, bus_in[7:0]};
      end
    end else if (port8_in) begin
      // 8-bit port: only upper lane valid, high byte only
      bus_out = {wdata_in[15:8], wdata_in[15:8]};
      rdata_out = {8'h00, bus_in[15:8]};
    end
  end
endmodule

// File: tb/ebc_bus_ctrl_chk.sv
module ebc_bus_ctrl_chk (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic req_in,
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic bus_error_out,
  input wire logic [3:0] ack_option_in,
  input wire logic [23:0] address_out,
  input wire logic [1:0] transfer_size_out,
  input wire logic [2:0] function_code_out,
  input wire logic rw_out,
  input wire logic address_strobe_n_out,
  input wire logic data_strobe_n_out,
  input wire logic data_oe_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // cycles spent with address strobe low; bounds the monitor
  logic [7:0] low_cnt_reg;
  always_ff @(posedge clk_in) begin
    if (rst_in || address_strobe_n_out) low_cnt_reg <= 8'h00;
    else low_cnt_reg <= low_cnt_reg + 8'h01;
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  a_take_sets_busy: assert property (ce_in && req_in && !busy_out |=> busy_out)
    else $error("request not taken");
  a_freeze_holds: assert property (!ce_in |=> $stable(busy_out))
    else $error("state moved with clock enable low");
  a_addr_held: assert property (!address_strobe_n_out && !$past(address_strobe_n_out) |->
    $stable(address_out) && $stable(transfer_size_out))
    else $error("address moved during strobe");
  a_fc_held: assert property (!address_strobe_n_out && !$past(address_strobe_n_out) |->
    $stable(function_code_out))
    else $error("function code moved during strobe");
  a_min_three: assert property ($fell(address_strobe_n_out) |-> !done_out [*2])
    else $error("cycle shorter than three clocks");
  a_fast_done: assert property ($fell(address_strobe_n_out) &&
    ack_option_in == ebc_pkg::EBC_ACK_OPT_FAST |-> ##4 done_out)
    else $error("fast cycle not two clocks");
  a_fast_write_ds: assert property (!address_strobe_n_out && !rw_out &&
    ack_option_in == ebc_pkg::EBC_ACK_OPT_FAST |-> data_strobe_n_out)
    else $error("data strobe on fast write");
  a_done_ends: assert property (done_out |-> address_strobe_n_out && data_strobe_n_out)
    else $error("strobes still low at end");
  a_monitor_bound: assert property (low_cnt_reg <= 8'h48)
    else $error("bus monitor did not end cycle");
  a_oe_write: assert property (data_oe_out |-> !rw_out)
    else $error("data driven on read");
  c_err: cover property (done_out && bus_error_out);
  c_ok: cover property (done_out && !bus_error_out);
  c_fast: cover property ($fell(address_strobe_n_out) && ack_option_in == 4'hE);
endmodule

// File: tb/ebc_periph_model.sv
// memory on the far side; mode 0 ack, 1 error, 2 error+halt, 3 silent, 4 halt+ack
module ebc_periph_model (
  input wire logic clk_in,
  input wire logic as_n_in,
  input wire logic rw_in,
  input wire logic [23:0] addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic oe_in,
  input wire logic port8_in,
  input wire logic [2:0] mode_in,
  input wire logic [3:0] wait_in,
  output logic [15:0] data_out,
  output logic [1:0] ack_n_out,
  output logic bus_error_line_n_out,
  output logic halt_n_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [16];
  logic [15:0] last = 16'h0000;
  int cnt = 0;
  initial {data_out, ack_n_out, bus_error_line_n_out, halt_n_out} = {16'hFFFF, 4'hF};
  // answers on the falling edge, so its lines are settled at the next rising edge
  always @(negedge clk_in) begin
    if (as_n_in) begin
      // released lines never keep the old value
      cnt <= 0;
      ack_n_out <= 2'h3;
      {bus_error_line_n_out, halt_n_out} <= 2'h3;
      data_out <= ~last;
    end else begin
      cnt <= cnt + 1;
      if (oe_in) mem[addr_in[4:1]] <= port8_in ? {wdata_in[15:8], 8'h00} : wdata_in;
      if (rw_in) begin
        data_out <= mem[addr_in[4:1]];
        last <= mem[addr_in[4:1]];
      end
      if (cnt >= int'(wait_in)) begin
        if (mode_in == 3'h0 || mode_in == 3'h4) ack_n_out <= port8_in ? 2'h2 : 2'h1;
        if (mode_in == 3'h1 || mode_in == 3'h2) bus_error_line_n_out <= 1'b0;
        if (mode_in == 3'h2 || mode_in == 3'h4) halt_n_out <= 1'b0;
      end
    end
  end
endmodule

// File: tb/tb_ebc_bus_ctrl.sv
module tb_ebc_bus_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_in = 0, rst_in = 1, ce_in = 1, req_in = 0, write_in = 0, port8 = 0;
  logic [1:0] size_in = 0, monitor_timeout_field_in = 0, size_acknowledge_n_in;
  logic [23:0] addr_in = 0, address_out, seen_a;
  logic [2:0] fc_in = 0, function_code_out, seen_fc, mode = 0;
  logic [31:0] wdata_in = 0, rdata_out;
  logic [3:0] ack_option_in = 0, wt = 4'h3;
  logic busy_out, done_out, bus_error_out, rw_out, data_oe_out, got_err;
  logic address_strobe_n_out, data_strobe_n_out, bus_error_line_n_in, halt_n_in;
  logic [1:0] transfer_size_out;
  logic [15:0] data_out, data_in;
  int fail_count = 0, cmp_count = 0, cyc;
  always #25 clk_in = ~clk_in;
  ebc_bus_ctrl dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in), .req_in(req_in),
    .write_in(write_in), .size_in(size_in), .addr_in(addr_in), .fc_in(fc_in),
    .wdata_in(wdata_in), .ack_option_in(ack_option_in),
    .monitor_timeout_field_in(monitor_timeout_field_in), .busy_out(busy_out),
    .done_out(done_out), .bus_error_out(bus_error_out), .rdata_out(rdata_out),
    .address_out(address_out), .transfer_size_out(transfer_size_out),
    .function_code_out(function_code_out), .rw_out(rw_out),
    .address_strobe_n_out(address_strobe_n_out),
    .data_strobe_n_out(data_strobe_n_out), .data_out(data_out),
    .data_oe_out(data_oe_out), .data_in(data_in),
    .size_acknowledge_n_in(size_acknowledge_n_in),
    .bus_error_line_n_in(bus_error_line_n_in), .halt_n_in(halt_n_in));
  ebc_periph_model peer (.clk_in(clk_in), .as_n_in(address_strobe_n_out), .rw_in(rw_out),
    .addr_in(address_out), .wdata_in(data_out), .oe_in(data_oe_out), .port8_in(port8),
    .mode_in(mode), .wait_in(wt), .data_out(data_in), .ack_n_out(size_acknowledge_n_in),
    .bus_error_line_n_out(bus_error_line_n_in), .halt_n_out(halt_n_in));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask
  // one transfer; entered just after an edge, leaves just after done
  task automatic op(input logic w, input logic [1:0] sz, input logic [23:0] a,
    input logic [2:0] fc, input logic [31:0] wd);
    {write_in, size_in, addr_in, fc_in, wdata_in, req_in} = {w, sz, a, fc, wd, 1'b1};
    cyc = 0;
    @(posedge clk_in) #2 req_in = 1'b0;
    while (done_out !== 1'b1 && cyc < 300) begin
      if (address_strobe_n_out === 1'b0) {seen_a, seen_fc} = {address_out, function_code_out};
      @(posedge clk_in) #2 cyc++;
    end
    if (cyc >= 300) chk(0, 1);
    got_err = bus_error_out;
  endtask
  task automatic end_sim();
    if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    end_sim();
  end
  initial begin
    logic [3:0] ty [3] = '{4'h0, 4'h3, 4'hF};
    logic [2:0] em [3] = '{3'h1, 3'h2, 3'h4};
    repeat (16) @(posedge clk_in);
    #2 rst_in = 0;
    op(1, 2'h2, 24'h10, 3'h5, 32'hA55A); chk(got_err, 0);
    op(0, 2'h2, 24'h10, 3'h5, 0); chk(rdata_out[15:0], 16'hA55A);
    op(1, 2'h0, 24'h20, 3'h5, 32'h12345678);
    op(0, 2'h0, 24'h20, 3'h5, 0); chk(rdata_out, 32'h12345678);
    port8 = 1;
    op(1, 2'h1, 24'h31, 3'h1, 32'h5A);
    op(0, 2'h1, 24'h31, 3'h1, 0); chk(rdata_out[7:0], 8'h5A);
    {port8, ack_option_in, mode} = {1'b0, 4'hE, 3'h3};
    op(1, 2'h2, 24'h40, 3'h5, 32'hC33C);
    op(0, 2'h2, 24'h40, 3'h5, 0); chk(rdata_out[15:0], 16'hC33C);
    ack_option_in = 0;
    for (int i = 0; i < 3; i++) begin
      mode = em[i];
      op(0, 2'h2, 24'h50, 3'h5, 0); chk(got_err, i < 2);
    end
    mode = 3'h3;
    for (int f = 0; f < 4; f++) begin
      monitor_timeout_field_in = 2'(f);
      op(0, 2'h2, 24'h60, 3'h5, 0); chk(got_err, 1);
      chk(cyc > (64 >> f) && cyc < (64 >> f) + 12, 1);
    end
    mode = 0;
    for (int i = 0; i < 3; i++) begin
      op(0, 2'h2, {4'h0, ty[i], 16'h0002}, 3'h7, 0); chk(seen_fc, 3'h7);
      chk(seen_a[19:16], ty[i]);
    end
    {ce_in, req_in} = 2'b01;
    repeat (3) @(posedge clk_in);
    #2 chk(busy_out, 0);
    {ce_in, req_in} = 2'b10;
    end_sim();
  end
endmodule
bind ebc_bus_ctrl ebc_bus_ctrl_chk chk_i (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
  .req_in(req_in), .busy_out(busy_out), .done_out(done_out), .bus_error_out(bus_error_out),
  .ack_option_in(ack_option_in), .address_out(address_out),
  .transfer_size_out(transfer_size_out), .function_code_out(function_code_out),
  .rw_out(rw_out), .address_strobe_n_out(address_strobe_n_out),
  .data_strobe_n_out(data_strobe_n_out), .data_oe_out(data_oe_out));
